// ### hw/xdata_pkg.sv
package xdata_pkg;
  // Special function register addresses (core-side direct space)
  localparam logic [7:0] PTR_SELECT_ADDR = 8'h86;
  localparam logic [7:0] PTR_A_UPPER_ADDR = 8'h93;
  localparam logic [7:0] PTR_B_UPPER_ADDR = 8'h95;
  localparam logic [7:0] IND_UPPER_ADDR = 8'hea;
  localparam logic [7:0] IND_MIDDLE_ADDR = 8'hb3;
  // Fast port register addresses: base plus 3 * slot
  localparam logic [7:0] FAST_PORT_BASE = 8'hc0;
  localparam int FAST_PORT_COUNT = 9;
  localparam logic [7:0] FAST_OFS_DATA = 8'h00;
  localparam logic [7:0] FAST_OFS_SELECT = 8'h01;
  localparam logic [7:0] FAST_OFS_STATE = 8'h02;
  // Port numbers that carry the fast register set, by slot
  localparam logic [3:0] FAST_PORT_NUM [FAST_PORT_COUNT] =
    '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'hf};
  localparam int PORT_COUNT = 16;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic PTR_SELECT_RESET = 1'b0;
  // Data space map
  localparam logic [23:0] SRAM_LAST = 24'h001fff;
  localparam logic [23:0] ONCHIP_LAST = 24'h7fffff;
  localparam logic [23:0] EXT_FIRST = 24'h800000;
  // Address source selection for external data moves
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_POINTER = 2'b01,
    SRC_WORKREG = 2'b10
  } addr_src_t;
  // Decoded target region
  typedef enum logic [1:0] {
    REGION_SRAM = 2'b00,
    REGION_ONCHIP = 2'b01,
    REGION_EXTERNAL = 2'b10
  } region_t;
endpackage : xdata_pkg

// ### hw/fast_port_bank.sv
`timescale 1ns/1ps
// Storage for the fast output data and select bytes of all fast ports
module fast_port_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [3:0] wr_slot,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_slot,
  input wire logic rd_sel,
  output logic [7:0] rd_data_ff,
  output logic [8*xdata_pkg::FAST_PORT_COUNT-1:0] data_flat,
  output logic [8*xdata_pkg::FAST_PORT_COUNT-1:0] select_flat
);
  logic [7:0] data_mem_ff [xdata_pkg::FAST_PORT_COUNT];
  logic [7:0] select_mem_ff [xdata_pkg::FAST_PORT_COUNT];

  genvar g;
  generate
    for (g = 0; g < xdata_pkg::FAST_PORT_COUNT; g++) begin : g_slot
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          data_mem_ff[g] <= xdata_pkg::BYTE_RESET;
          select_mem_ff[g] <= xdata_pkg::BYTE_RESET;
        end else if (wr_en && wr_slot == 4'(g)) begin
          if (wr_sel) begin
            select_mem_ff[g] <= wr_data;
          end else begin
            data_mem_ff[g] <= wr_data;
          end
        end
      end
      assign data_flat[8*g +: 8] = data_mem_ff[g];
      assign select_flat[8*g +: 8] = select_mem_ff[g];
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= xdata_pkg::BYTE_RESET;
    end else if (rd_slot < 4'(xdata_pkg::FAST_PORT_COUNT)) begin
      rd_data_ff <= rd_sel ? select_mem_ff[rd_slot] : data_mem_ff[rd_slot];
    end else begin
      rd_data_ff <= xdata_pkg::BYTE_RESET;
    end
  end
endmodule : fast_port_bank

// ### hw/xdata_address_ext_port_sfr.sv
`timescale 1ns/1ps
// Contract
// - The pointer select register picks data pointer a or b for all pointer-based instructions.
// - The four extension registers shape the address only during external data moves.
// - A pointer-based external move takes its top address byte from the selected pointer's extension register.
// - A working-register external move takes its top byte from indirect_upper and next byte from indirect_middle.
// - Every external data move produces a full 24-bit address in a 16 MB space.
// - Low addresses decode to on-chip SRAM; the on-chip strobe covers the whole lower half, SRAM addresses included.
// - Addresses in the top half of the space go to the external memory interface.
// - Fast output data registers exist only for ports 0 to 6, 12 and 15 and hold each port's output state.
// - A set fast select bit drives the pin from the matching fast output data bit.
// - A clear fast select bit drives the pin from the hub-side port output data bit.
// - The fast pin state register is read-only and returns the current pin levels.
// - The fast path covers a subset only; the full port registers stay reachable through the peripheral hub.
module xdata_address_ext_port_sfr (
  input wire logic clk,
  input wire logic resetn,
  // Special function register access from the core
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_ff,
  output logic sfr_hit_ff,
  // Instruction context from the core
  input wire logic [15:0] data_pointer_a,
  input wire logic [15:0] data_pointer_b,
  input wire logic [7:0] working_reg,
  input wire logic ext_move_ptr,
  input wire logic ext_move_reg,
  output logic pointer_select_ff,
  // Formed data space address and target region
  output logic [23:0] xdata_addr_ff,
  output logic xdata_valid_ff,
  output logic sram_sel_ff,
  output logic onchip_sel_ff,
  output logic external_memory_interface_sel_ff,
  // Port pins; the hub side keeps the full register set
  input wire logic [8*xdata_pkg::PORT_COUNT-1:0] hub_port_output_data,
  input wire logic [8*xdata_pkg::PORT_COUNT-1:0] pin_level,
  output logic [8*xdata_pkg::PORT_COUNT-1:0] pin_out_ff
);
  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers
  function automatic logic [4:0] fast_decode(input logic [7:0] addr);
    logic [7:0] rel;
    logic [7:0] quo;
    logic [3:0] slot;
    logic [1:0] kind;
    rel = addr - xdata_pkg::FAST_PORT_BASE;
    // Range check on the full quotient so high addresses cannot alias low slots
    quo = rel / 8'd3;
    slot = quo[3:0];
    kind = 2'(rel % 8'd3);
    if (addr < xdata_pkg::FAST_PORT_BASE || quo >= 8'(xdata_pkg::FAST_PORT_COUNT)) begin
      fast_decode = {1'b0, 4'hf};
    end else begin
      fast_decode = {1'b1, slot};
    end
    if (kind == 2'd3) begin
      fast_decode = {1'b0, 4'hf};
    end
  endfunction : fast_decode

  function automatic logic [1:0] fast_kind(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - xdata_pkg::FAST_PORT_BASE;
    fast_kind = 2'(rel % 8'd3);
  endfunction : fast_kind

  function automatic xdata_pkg::region_t region_of(input logic [23:0] a);
    if (a <= xdata_pkg::SRAM_LAST) begin
      region_of = xdata_pkg::REGION_SRAM;
    end else if (a <= xdata_pkg::ONCHIP_LAST) begin
      region_of = xdata_pkg::REGION_ONCHIP;
    end else begin
      region_of = xdata_pkg::REGION_EXTERNAL;
    end
  endfunction : region_of

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  logic [8*xdata_pkg::PORT_COUNT-1:0] pin_meta_ff;
  logic [8*xdata_pkg::PORT_COUNT-1:0] pin_sync_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_level;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extension and select registers
  logic [7:0] pointer_a_upper_byte_ff;
  logic [7:0] pointer_b_upper_byte_ff;
  logic [7:0] indirect_upper_byte_ff;
  logic [7:0] indirect_middle_byte_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pointer_select_ff <= xdata_pkg::PTR_SELECT_RESET;
    end else if (sfr_wr && sfr_addr == xdata_pkg::PTR_SELECT_ADDR) begin
      pointer_select_ff <= sfr_wdata[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pointer_a_upper_byte_ff <= xdata_pkg::BYTE_RESET;
      pointer_b_upper_byte_ff <= xdata_pkg::BYTE_RESET;
      indirect_upper_byte_ff <= xdata_pkg::BYTE_RESET;
      indirect_middle_byte_ff <= xdata_pkg::BYTE_RESET;
    end else if (sfr_wr) begin
      case (sfr_addr)
        xdata_pkg::PTR_A_UPPER_ADDR: pointer_a_upper_byte_ff <= sfr_wdata;
        xdata_pkg::PTR_B_UPPER_ADDR: pointer_b_upper_byte_ff <= sfr_wdata;
        xdata_pkg::IND_UPPER_ADDR: indirect_upper_byte_ff <= sfr_wdata;
        xdata_pkg::IND_MIDDLE_ADDR: indirect_middle_byte_ff <= sfr_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data space address formation
  xdata_pkg::addr_src_t src;
  logic [23:0] nxt_xdata_addr;
  always_comb begin
    src = xdata_pkg::SRC_NONE;
    if (ext_move_ptr) begin
      src = xdata_pkg::SRC_POINTER;
    end else if (ext_move_reg) begin
      src = xdata_pkg::SRC_WORKREG;
    end
    case (src)
      xdata_pkg::SRC_POINTER: begin
        nxt_xdata_addr = pointer_select_ff ? {pointer_b_upper_byte_ff, data_pointer_b}
                                           : {pointer_a_upper_byte_ff, data_pointer_a};
      end
      xdata_pkg::SRC_WORKREG: begin
        nxt_xdata_addr = {indirect_upper_byte_ff, indirect_middle_byte_ff, working_reg};
      end
      default: nxt_xdata_addr = xdata_addr_ff;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xdata_addr_ff <= '0;
      xdata_valid_ff <= 1'b0;
      sram_sel_ff <= 1'b0;
      onchip_sel_ff <= 1'b0;
      external_memory_interface_sel_ff <= 1'b0;
    end else begin
      xdata_addr_ff <= nxt_xdata_addr;
      xdata_valid_ff <= (src != xdata_pkg::SRC_NONE);
      sram_sel_ff <= (src != xdata_pkg::SRC_NONE) && region_of(nxt_xdata_addr) == xdata_pkg::REGION_SRAM;
      onchip_sel_ff <= (src != xdata_pkg::SRC_NONE) &&
                       region_of(nxt_xdata_addr) != xdata_pkg::REGION_EXTERNAL;
      external_memory_interface_sel_ff <= (src != xdata_pkg::SRC_NONE) &&
                                          region_of(nxt_xdata_addr) == xdata_pkg::REGION_EXTERNAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast port registers
  logic [4:0] dec;
  logic [1:0] kind;
  logic fast_wr;
  logic [7:0] bank_rdata;
  logic [8*xdata_pkg::FAST_PORT_COUNT-1:0] fast_data;
  logic [8*xdata_pkg::FAST_PORT_COUNT-1:0] fast_select;
  assign dec = fast_decode(sfr_addr);
  assign kind = fast_kind(sfr_addr);
  // Pin state is read-only: writes to it are dropped
  assign fast_wr = sfr_wr && dec[4] && kind != 2'(xdata_pkg::FAST_OFS_STATE);

  fast_port_bank u_bank (
    .clk(clk),
    .resetn(resetn),
    .wr_en(fast_wr),
    .wr_sel(kind == 2'(xdata_pkg::FAST_OFS_SELECT)),
    .wr_slot(dec[3:0]),
    .wr_data(sfr_wdata),
    .rd_slot(dec[3:0]),
    .rd_sel(kind == 2'(xdata_pkg::FAST_OFS_SELECT)),
    .rd_data_ff(bank_rdata),
    .data_flat(fast_data),
    .select_flat(fast_select)
  );

  // Pin output mux; ports without fast registers follow the hub side only
  genvar p;
  generate
    for (p = 0; p < xdata_pkg::FAST_PORT_COUNT; p++) begin : g_fast
      localparam int PN = int'(xdata_pkg::FAST_PORT_NUM[p]);
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pin_out_ff[8*PN +: 8] <= xdata_pkg::BYTE_RESET;
        end else begin
          pin_out_ff[8*PN +: 8] <= (fast_select[8*p +: 8] & fast_data[8*p +: 8]) |
                                   (~fast_select[8*p +: 8] & hub_port_output_data[8*PN +: 8]);
        end
      end
    end
    for (p = 7; p < 12; p++) begin : g_hub_mid
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pin_out_ff[8*p +: 8] <= xdata_pkg::BYTE_RESET;
        end else begin
          pin_out_ff[8*p +: 8] <= hub_port_output_data[8*p +: 8];
        end
      end
    end
    for (p = 13; p < 15; p++) begin : g_hub_hi
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pin_out_ff[8*p +: 8] <= xdata_pkg::BYTE_RESET;
        end else begin
          pin_out_ff[8*p +: 8] <= hub_port_output_data[8*p +: 8];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data, two cycles after the read strobe
  logic rd_state_ff;
  logic rd_bank_ff;
  logic [7:0] rd_direct_ff;
  logic [7:0] state_byte_ff;
  logic hit_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_state_ff <= 1'b0;
      rd_bank_ff <= 1'b0;
      rd_direct_ff <= '0;
      state_byte_ff <= '0;
      hit_ff <= 1'b0;
    end else begin
      rd_state_ff <= dec[4] && kind == 2'(xdata_pkg::FAST_OFS_STATE);
      rd_bank_ff <= dec[4] && kind != 2'(xdata_pkg::FAST_OFS_STATE);
      state_byte_ff <= dec[4] ? pin_sync_ff[8*int'(xdata_pkg::FAST_PORT_NUM[dec[3:0]]) +: 8] : '0;
      hit_ff <= sfr_rd;
      case (sfr_addr)
        xdata_pkg::PTR_SELECT_ADDR: rd_direct_ff <= {7'h00, pointer_select_ff};
        xdata_pkg::PTR_A_UPPER_ADDR: rd_direct_ff <= pointer_a_upper_byte_ff;
        xdata_pkg::PTR_B_UPPER_ADDR: rd_direct_ff <= pointer_b_upper_byte_ff;
        xdata_pkg::IND_UPPER_ADDR: rd_direct_ff <= indirect_upper_byte_ff;
        xdata_pkg::IND_MIDDLE_ADDR: rd_direct_ff <= indirect_middle_byte_ff;
        default: rd_direct_ff <= '0;
      endcase
    end
  end

  // Second stage so the bank read and the direct read line up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_ff <= '0;
      sfr_hit_ff <= 1'b0;
    end else begin
      sfr_hit_ff <= hit_ff;
      if (rd_state_ff) begin
        sfr_rdata_ff <= state_byte_ff;
      end else if (rd_bank_ff) begin
        sfr_rdata_ff <= bank_rdata;
      end else begin
        sfr_rdata_ff <= rd_direct_ff;
      end
    end
  end
endmodule : xdata_address_ext_port_sfr

// ### testbench/xdata_checker_sva.sv
`timescale 1ns/1ps
module xdata_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_hit_ff,
  input wire logic [15:0] data_pointer_a,
  input wire logic [15:0] data_pointer_b,
  input wire logic [7:0] working_reg,
  input wire logic ext_move_ptr,
  input wire logic ext_move_reg,
  input wire logic pointer_select_ff,
  input wire logic [23:0] xdata_addr_ff,
  input wire logic xdata_valid_ff,
  input wire logic sram_sel_ff,
  input wire logic onchip_sel_ff,
  input wire logic external_memory_interface_sel_ff,
  input wire logic [8*xdata_pkg::PORT_COUNT-1:0] hub_port_output_data,
  input wire logic [8*xdata_pkg::PORT_COUNT-1:0] pin_out_ff
);
  logic [15:0] ptr_ff;
  logic [7:0] hub7_ff;
  // Pointer chosen at the move edge, and port 7 which has no fast registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_ff <= 16'h0000;
      hub7_ff <= 8'h00;
    end else begin
      ptr_ff <= pointer_select_ff ? data_pointer_b : data_pointer_a;
      hub7_ff <= hub_port_output_data[63:56];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  move_valid_a: assert property ((ext_move_ptr || ext_move_reg) |=> xdata_valid_ff)
    else $error("move gave no valid");
  idle_quiet_a: assert property (!(ext_move_ptr || ext_move_reg) |=> !xdata_valid_ff && $stable(xdata_addr_ff))
    else $error("address changed without a move");
  ptr_low_a: assert property (ext_move_ptr |=> xdata_addr_ff[15:0] == ptr_ff)
    else $error("low address not from selected pointer");
  reg_low_a: assert property ((ext_move_reg && !ext_move_ptr) |=> xdata_addr_ff[7:0] == $past(working_reg))
    else $error("low byte not from working register");
  region_split_a: assert property (xdata_valid_ff |-> external_memory_interface_sel_ff == xdata_addr_ff[23]
    && onchip_sel_ff == !xdata_addr_ff[23])
    else $error("wrong half of data space");
  sram_decode_a: assert property (xdata_valid_ff |-> sram_sel_ff == (xdata_addr_ff <= xdata_pkg::SRAM_LAST))
    else $error("sram decode wrong");
  strobe_qual_a: assert property (!xdata_valid_ff |-> !(sram_sel_ff || onchip_sel_ff
    || external_memory_interface_sel_ff))
    else $error("region strobe without valid");
  read_answer_a: assert property (sfr_rd |-> ##2 sfr_hit_ff)
    else $error("read not answered");
  hit_cause_a: assert property (sfr_hit_ff |-> $past(sfr_rd, 2))
    else $error("hit without read");
  select_write_a: assert property ((sfr_wr && sfr_addr == 8'h86) |=>
    {7'h00, pointer_select_ff} == ($past(sfr_wdata) & 8'h01))
    else $error("pointer select not written");
  hub_only_a: assert property (pin_out_ff[63:56] == hub7_ff)
    else $error("port 7 not from hub data");
  cover property (ext_move_ptr && pointer_select_ff);
  cover property (ext_move_reg && !ext_move_ptr);
  cover property (xdata_valid_ff && external_memory_interface_sel_ff);
  cover property (sfr_hit_ff);
endmodule : xdata_checker
bind xdata_address_ext_port_sfr xdata_checker chk (.clk, .resetn, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
  .sfr_hit_ff, .data_pointer_a, .data_pointer_b, .working_reg, .ext_move_ptr, .ext_move_reg,
  .pointer_select_ff, .xdata_addr_ff, .xdata_valid_ff, .sram_sel_ff, .onchip_sel_ff,
  .external_memory_interface_sel_ff, .hub_port_output_data, .pin_out_ff);

// ### testbench/pad_model.sv
`timescale 1ns/1ps
module pad_model (
  input wire logic [8*xdata_pkg::PORT_COUNT-1:0] pin_drive,
  output logic [8*xdata_pkg::PORT_COUNT-1:0] pin_level
);
  // Pads settle to the driven level after a buffer delay
  assign #2 pin_level = pin_drive;
endmodule : pad_model

// ### testbench/tb_xdata_address_ext_port_sfr.sv
`timescale 1ns/1ps
module tb_xdata_address_ext_port_sfr;
  localparam int W = 8*xdata_pkg::PORT_COUNT;
  logic clk, resetn, sfr_wr, sfr_rd, sfr_hit_ff, ext_move_ptr, ext_move_reg, pointer_select_ff;
  logic xdata_valid_ff, sram_sel_ff, onchip_sel_ff, external_memory_interface_sel_ff;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_ff, working_reg, a, e;
  logic [15:0] data_pointer_a, data_pointer_b;
  logic [23:0] xdata_addr_ff;
  logic [W-1:0] hub_port_output_data, pin_level, pin_out_ff;
  int fails, checks_done, p;
  xdata_address_ext_port_sfr dut (.clk, .resetn, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata_ff,
    .sfr_hit_ff, .data_pointer_a, .data_pointer_b, .working_reg, .ext_move_ptr, .ext_move_reg,
    .pointer_select_ff, .xdata_addr_ff, .xdata_valid_ff, .sram_sel_ff, .onchip_sel_ff,
    .external_memory_interface_sel_ff, .hub_port_output_data, .pin_level, .pin_out_ff);
  pad_model pads (.pin_drive(pin_out_ff), .pin_level(pin_level));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    sfr_wr = 1'b1;
    sfr_addr = ad;
    sfr_wdata = d;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    // One idle edge so a following write does not raise the strobe it just lowered
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] x);
    sfr_rd = 1'b1;
    sfr_addr = ad;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    @(posedge clk);
    #1;
    check(sfr_hit_ff, 1'b1);
    check(sfr_rdata_ff, x);
  endtask : rd
  // Move request stays up so consecutive calls are back to back
  task automatic mv(input logic ptr, input logic [23:0] x);
    ext_move_ptr = ptr;
    ext_move_reg = !ptr;
    @(posedge clk);
    #1;
    check(xdata_valid_ff, 1'b1);
    check(xdata_addr_ff, x);
    check({sram_sel_ff, onchip_sel_ff, external_memory_interface_sel_ff}, {x <= 24'h001fff, !x[23], x[23]});
  endtask : mv
  task automatic rel();
    ext_move_ptr = 1'b0;
    ext_move_reg = 1'b0;
    @(posedge clk);
    #1;
  endtask : rel
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  // Whole run is about 190 cycles; allow over thirty times that
  initial begin
    #600000;
    fails++;
    conclude();
  end
  initial begin
    {sfr_wr, sfr_rd, ext_move_ptr, ext_move_reg} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    data_pointer_a = 16'h1234;
    data_pointer_b = 16'hbeef;
    working_reg = 8'hff;
    for (int k = 0; k < 16; k++) hub_port_output_data[8*k+:8] = 8'h11 * 8'(k);
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    foreach (xdata_pkg::FAST_PORT_NUM[s]) rd(8'hc0 + 8'(3*s), 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h93, 8'h00);
    rd(8'h95, 8'h00);
    rd(8'hea, 8'h00);
    rd(8'hb3, 8'h00);
    $display("test reset_values done");
    wr(8'h93, 8'h12);
    wr(8'h95, 8'h9a);
    wr(8'hea, 8'h00);
    wr(8'hb3, 8'h1f);
    mv(1'b1, 24'h121234);
    mv(1'b0, 24'h001fff);
    rel();
    wr(8'h86, 8'h01);
    check(pointer_select_ff, 1'b1);
    wr(8'hea, 8'h7f);
    wr(8'hb3, 8'hff);
    mv(1'b1, 24'h9abeef);
    mv(1'b0, 24'h7fffff);
    rel();
    rd(8'h86, 8'h01);
    rd(8'h95, 8'h9a);
    rd(8'hea, 8'h7f);
    rd(8'h80, 8'h00);
    $display("test address_forming done");
    foreach (xdata_pkg::FAST_PORT_NUM[s]) begin
      a = 8'hc0 + 8'(3*s);
      wr(a, 8'ha5 ^ 8'(s));
      wr(a + 8'h01, 8'h0f);
      wr(a + 8'h02, 8'hff);
    end
    repeat (4) @(posedge clk);
    #1;
    foreach (xdata_pkg::FAST_PORT_NUM[s]) begin
      a = 8'hc0 + 8'(3*s);
      p = int'(xdata_pkg::FAST_PORT_NUM[s]);
      e = ((8'ha5 ^ 8'(s)) & 8'h0f) | (hub_port_output_data[8*p+:8] & 8'hf0);
      check(pin_out_ff[8*p+:8], e);
      rd(a, 8'ha5 ^ 8'(s));
      rd(a + 8'h01, 8'h0f);
      rd(a + 8'h02, e);
    end
    for (int k = 7; k < 15; k++) if (k != 12) check(pin_out_ff[8*k+:8], hub_port_output_data[8*k+:8]);
    wr(8'hc1, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check(pin_out_ff[7:0], hub_port_output_data[7:0]);
    wr(8'hf0, 8'h5a);
    rd(8'hf0, 8'h00);
    rd(8'hc0, 8'ha5);
    $display("test fast_ports done");
    conclude();
  end
endmodule : tb_xdata_address_ext_port_sfr
